/* File: sfrb_bank.sv */
// special-function register bank with power-on and warm reset domains
`timescale 1ns/100ps
// ****************************************
// ****************************************
module sfrb_bank #(
    parameter logic [7:0] FACTORY_TRIM = 8'h00
) (
    // clock and power-on reset
    input wire logic clock,
    input wire logic resetn,
    // warm reset causes, one-cycle pulses from same-clock logic
    input wire sfrb_pkg::sfrb_reset_t warmReset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // settings towards the peripherals
    output sfrb_pkg::sfrb_ctrl_t control,
    // port pins
    output logic [7:0] portOut,
    output logic [7:0] portOe,
    // interrupt
    output logic irq
);
    import sfrb_pkg::*;

    // ****************************************
    // bus slave
    // ****************************************
    logic addrPhase;
    logic addrOk;
    logic wrPend_r;
    logic rdPend_r;
    logic accOk_r;
    sfrb_idx_t accIdx_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic [7:0] readByte;
    logic wrEn;
    logic [7:0] wrByte;
    logic warmAny;

    assign addrPhase = hsel & htrans[1] & hready;
    assign addrOk = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);
    assign wrEn = wrPend_r;
    assign wrByte = hwdata[7:0];
    // warm reset from any source except power-on
    assign warmAny = |warmReset;

    // reads take one wait state so a write just before is seen
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wrPend_r <= 1'b0;
            rdPend_r <= 1'b0;
            accOk_r <= 1'b0;
            accIdx_r <= '0;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h00000000;
            hresp_r <= 1'b0;
        end else begin
            wrPend_r <= addrPhase & hwrite & addrOk;
            rdPend_r <= addrPhase & ~hwrite;
            hresp_r <= 1'b0;
            if (addrPhase) begin
                accIdx_r <= haddr[11:2];
                accOk_r <= addrOk;
            end
            if (addrPhase & ~hwrite) begin
                hreadyout_r <= 1'b0;
            end else begin
                hreadyout_r <= 1'b1;
            end
            if (rdPend_r) begin
                hrdata_r <= accOk_r ? {24'h000000, readByte} : 32'h00000000;
            end
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;

    // ****************************************
    // plain storage registers
    // ****************************************
    logic [7:0] tableReg_r [TABLE_COUNT];

    for (genvar i = 0; i < TABLE_COUNT; i++) begin : g_table
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                tableReg_r[i] <= TABLE_RESET[i];
            end else if (warmAny && !TABLE_POR_ONLY[i]) begin
                // rtc registers skip this branch
                tableReg_r[i] <= TABLE_RESET[i];
            end else if (wrEn && accIdx_r == TABLE_INDEX[i]) begin
                tableReg_r[i] <= wrByte;
            end
        end
    end

    // ****************************************
    // oscillator trim, power-on only
    // ****************************************
    logic [7:0] trim_r;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            trim_r <= FACTORY_TRIM;
        end else if (wrEn && accIdx_r == IDX_RC_OSCILLATOR_TUNING) begin
            // warm resets never reach here, so the trimmed value survives them
            trim_r <= wrByte;
        end
    end

    // ****************************************
    // watchdog control
    // ****************************************
    logic [7:0] wdControl_r;
    logic [7:0] wdControl_nxt;

    always_comb begin
        wdControl_nxt = wdControl_r;
        if (wrEn && accIdx_r == IDX_WATCHDOG_CONTROL) begin
            wdControl_nxt = wrByte;
        end
        // a watchdog reset in the same cycle as a write still leaves the flag set
        if (warmReset.watchdog) begin
            wdControl_nxt[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wdControl_r <= RST_WATCHDOG_CONTROL;
        end else begin
            wdControl_r <= wdControl_nxt;
        end
    end

    // ****************************************
    // reset cause register
    // ****************************************
    logic [7:0] cause_r;
    logic [7:0] causeSet;
    logic [7:0] causeClr;

    assign causeSet = {2'b00, warmReset.brownout, 1'b0, warmReset.breakDetect,
                       warmReset.watchdog, warmReset.software, warmReset.external};
    assign causeClr = (wrEn && accIdx_r == IDX_RESET_CAUSE_REGISTER) ? wrByte : 8'h00;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cause_r <= RST_RESET_CAUSE_POR;
        end else begin
            // set wins over a clear in the same cycle
            cause_r <= ((cause_r & ~causeClr) | causeSet) & 8'h3F;
        end
    end

    // ****************************************
    // baud generator 0
    // ****************************************
    logic baudEnable_r;
    logic [7:0] baudRateLow_r;
    logic [7:0] baudRateHigh_r;
    logic baudRateWrite;
    logic baudRefused;

    assign baudRateWrite = wrEn && (accIdx_r == IDX_BAUD_GEN0_RATE_LOW || accIdx_r == IDX_BAUD_GEN0_RATE_HIGH);
    // a rate write while running would glitch the divider, so it is dropped
    assign baudRefused = baudRateWrite & baudEnable_r;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            baudEnable_r <= 1'b0;
            baudRateLow_r <= RST_ZERO;
            baudRateHigh_r <= RST_ZERO;
        end else if (warmAny) begin
            baudEnable_r <= 1'b0;
            baudRateLow_r <= RST_ZERO;
            baudRateHigh_r <= RST_ZERO;
        end else begin
            if (wrEn && accIdx_r == IDX_BAUD_GEN0_CONTROL) begin
                baudEnable_r <= wrByte[BAUD_GEN0_ENABLE_BIT];
            end
            if (!baudRefused && wrEn && accIdx_r == IDX_BAUD_GEN0_RATE_LOW) begin
                baudRateLow_r <= wrByte;
            end
            if (!baudRefused && wrEn && accIdx_r == IDX_BAUD_GEN0_RATE_HIGH) begin
                baudRateHigh_r <= wrByte;
            end
        end
    end

    // ****************************************
    // port drive
    // ****************************************
    logic [7:0] portDrive_r;
    logic [7:0] portData_r;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            portDrive_r <= RST_ZERO;
            portData_r <= RST_ZERO;
        end else if (warmAny) begin
            portDrive_r <= RST_ZERO;
            portData_r <= RST_ZERO;
        end else begin
            if (wrEn && accIdx_r == IDX_PORT_DRIVE) begin
                portDrive_r <= wrByte;
            end
            if (wrEn && accIdx_r == IDX_PORT_DATA) begin
                portData_r <= wrByte;
            end
        end
    end

    assign portOe = portDrive_r;
    assign portOut = portData_r;

    // ****************************************
    // interrupts
    // ****************************************
    logic [IRQ_W-1:0] irqStatus_r;
    logic [IRQ_W-1:0] irqStatus_nxt;
    logic [IRQ_W-1:0] irqEnable_r;
    logic [IRQ_W-1:0] irqEvents;
    logic [IRQ_W-1:0] irqClr;
    logic irq_r;

    assign irqEvents = {baudRefused, warmReset};
    assign irqClr = (wrEn && accIdx_r == IDX_IRQ_CLEAR) ? wrByte[IRQ_W-1:0] : '0;
    // set wins over a clear in the same cycle
    assign irqStatus_nxt = (irqStatus_r & ~irqClr) | irqEvents;

    // status and enable live in the power-on domain so a warm reset cause is still visible
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irqStatus_r <= '0;
            irqEnable_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irqStatus_r <= irqStatus_nxt;
            if (wrEn && accIdx_r == IDX_IRQ_ENABLE) begin
                irqEnable_r <= wrByte[IRQ_W-1:0];
            end
            irq_r <= |(irqStatus_nxt & irqEnable_r);
        end
    end

    assign irq = irq_r;

    // ****************************************
    // read mux and peripheral settings
    // ****************************************
    always_comb begin
        readByte = 8'h00;
        for (int k = 0; k < TABLE_COUNT; k++) begin
            if (accIdx_r == TABLE_INDEX[k]) begin
                readByte = tableReg_r[k];
            end
        end
        unique case (accIdx_r)
            IDX_RC_OSCILLATOR_TUNING: readByte = trim_r;
            IDX_WATCHDOG_CONTROL: readByte = wdControl_r;
            IDX_RESET_CAUSE_REGISTER: readByte = cause_r;
            IDX_IRQ_STATUS: readByte = {2'b00, irqStatus_r};
            IDX_IRQ_ENABLE: readByte = {2'b00, irqEnable_r};
            IDX_BAUD_GEN0_CONTROL: readByte = {7'h00, baudEnable_r};
            IDX_BAUD_GEN0_RATE_LOW: readByte = baudRateLow_r;
            IDX_BAUD_GEN0_RATE_HIGH: readByte = baudRateHigh_r;
            IDX_PORT_DRIVE: readByte = portDrive_r;
            IDX_PORT_DATA: readByte = portData_r;
            default: begin
            end
        endcase
    end

    assign control.watchdogControl = wdControl_r;
    assign control.oscTrim = trim_r;
    assign control.baudGen0Enable = baudEnable_r;
    assign control.baudGen0Rate = {baudRateHigh_r, baudRateLow_r};

endmodule

/* File: sfrb_bank_checker.sv */
// concurrent port checks for the special-function register bank
`timescale 1ns/100ps
module sfrb_bank_checker #(
    parameter logic [7:0] FACTORY_TRIM = 8'h00
) (
    // clock, resets
    input wire logic clock,
    input wire logic resetn,
    input wire sfrb_pkg::sfrb_reset_t warmReset,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // outputs
    input wire sfrb_pkg::sfrb_ctrl_t control,
    input wire logic [7:0] portOut,
    input wire logic [7:0] portOe,
    input wire logic irq
);
    import sfrb_pkg::*;
    // ****************************************
    // helper logic
    // ****************************************
    logic addrOk;
    logic wrData_r;
    assign addrOk = hsel && htrans[1] && hready;
    // marks a write data phase, so warm-reset checks skip a same-cycle write
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wrData_r <= 1'b0;
        end else begin
            wrData_r <= addrOk && hwrite;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // ****************************************
    // assertions
    // ****************************************
    bus_okay_a: assert property (hresp == 1'b0) else $error("error response seen");
    read_wait_a: assert property (addrOk && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait cycle wrong");
    write_nowait_a: assert property (addrOk && hwrite |=> hreadyout) else $error("write stalled");
    unmapped_read_a: assert property (addrOk && !hwrite && haddr[31:12] != 20'h0 |=> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    wd_flag_set_a: assert property (
        warmReset.watchdog |=> control.watchdogControl[1]) else $error("timeout flag not set");
    wd_keep_a: assert property (
        (|warmReset) && !warmReset.watchdog && !wrData_r |=> $stable(control.watchdogControl))
        else $error("watchdog control changed by warm reset");
    trim_keep_a: assert property (
        $changed(control.oscTrim) |-> $past(wrData_r)) else $error("trim changed without write");
    trim_por_a: assert property (
        $rose(resetn) |-> control.oscTrim == FACTORY_TRIM) else $error("trim not factory value");
    wd_por_a: assert property (
        $rose(resetn) |-> control.watchdogControl == 8'hE5) else $error("watchdog control reset value");
    ports_off_a: assert property (
        (|warmReset) && !wrData_r |=> portOe == 8'h00) else $error("port still driven");
    irq_cause_a: assert property ($rose(irq) |-> $past(|warmReset) || $past(wrData_r) || $past(wrData_r, 2))
        else $error("irq without cause");
endmodule

/* File: sfrb_bank_tb.sv */
// self-checking bench for the register bank reset domains
`timescale 1ns/100ps
module sfrb_bank_tb;
    import sfrb_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [7:0] TRIM_VAL = 8'h5A;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    sfrb_reset_t warmReset = '0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = '0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    sfrb_ctrl_t control;
    logic [7:0] portOut;
    logic [7:0] portOe;
    logic irq;
    logic [31:0] rdat;
    int fails = 0;
    int checksDone = 0;
    logic [7:0] keepVal [4] = '{8'h81, 8'h5C, 8'hC3, 8'h3C};
    sfrb_idx_t keepIdx [4] = '{IDX_RTC_CONTROL, IDX_RTC_COUNT_HIGH, IDX_RTC_COUNT_LOW, IDX_RC_OSCILLATOR_TUNING};
    assign hready = hreadyout;
    always #5 clock = ~clock;
    sfrb_bank #(.FACTORY_TRIM(TRIM_VAL)) i_dut (.clock(clock), .resetn(resetn), .warmReset(warmReset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .control(control),
        .portOut(portOut), .portOe(portOe), .irq(irq));
    // ****************************************
    // tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask
    // one single word transfer, address phase then data phase
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [7:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= addr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
    endtask
    function automatic logic [31:0] adr(input sfrb_idx_t idx);
        return {20'h0, idx, 2'b00};
    endfunction
    task automatic wr(input sfrb_idx_t idx, input logic [7:0] d);
        logic [31:0] unused;
        xfer(1'b1, adr(idx), d, unused);
    endtask
    task automatic rd_chk(input sfrb_idx_t idx, input logic [7:0] exp);
        logic [31:0] v;
        xfer(1'b0, adr(idx), 8'h00, v);
        check(v, {24'h0, exp});
    endtask
    task automatic pulse(input int b);
        warmReset <= sfrb_reset_t'(5'h01 << b);
        @(posedge clock);
        warmReset <= '0;
        repeat (2) @(posedge clock);
    endtask
    task automatic power_on();
        resetn <= 1'b0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        power_on();
        for (int i = 0; i < TABLE_COUNT; i++) begin
            rd_chk(TABLE_INDEX[i], TABLE_RESET[i]);
        end
        rd_chk(IDX_WATCHDOG_CONTROL, 8'hE5);
        rd_chk(IDX_RESET_CAUSE_REGISTER, 8'h30);
        rd_chk(IDX_RC_OSCILLATOR_TUNING, TRIM_VAL);
        check({24'h0, portOe}, 32'h0);
        for (int j = 0; j < 4; j++) begin
            wr(keepIdx[j], keepVal[j]);
        end
        wr(IDX_WATCHDOG_CONTROL, 8'hA4);
        wr(IDX_IRQ_ENABLE, 8'h01);
        // every warm cause in turn; the flag stays set once a watchdog reset hit
        for (int b = 0; b < 5; b++) begin
            wr(IDX_RESET_CAUSE_REGISTER, 8'hFF);
            wr(IDX_IRQ_CLEAR, 8'hFF);
            wr(IDX_STACK_POINTER, 8'h55);
            wr(IDX_PORT_DRIVE, 8'hF0);
            check({31'h0, irq}, 32'h0);
            pulse(b);
            check({31'h0, irq}, {31'h0, b == 0});
            rd_chk(IDX_WATCHDOG_CONTROL, b < 2 ? 8'hA4 : 8'hA6);
            rd_chk(IDX_RESET_CAUSE_REGISTER, b == 4 ? 8'h20 : 8'h01 << b);
            rd_chk(IDX_IRQ_STATUS, 8'h01 << b);
            rd_chk(IDX_STACK_POINTER, RST_STACK_POINTER);
            check({24'h0, portOe}, 32'h0);
            for (int j = 0; j < 4; j++) begin
                rd_chk(keepIdx[j], keepVal[j]);
            end
            check({24'h0, control.oscTrim}, 32'h3C);
        end
        wr(IDX_IRQ_ENABLE, 8'h10);
        rd_chk(IDX_IRQ_ENABLE, 8'h10);
        check({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_CLEAR, 8'h10);
        rd_chk(IDX_IRQ_CLEAR, 8'h00);
        check({31'h0, irq}, 32'h0);
        wr(IDX_BAUD_GEN0_RATE_LOW, 8'h34);
        wr(IDX_BAUD_GEN0_RATE_HIGH, 8'h12);
        wr(IDX_BAUD_GEN0_CONTROL, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h20);
        wr(IDX_BAUD_GEN0_RATE_HIGH, 8'hEE);
        rd_chk(IDX_IRQ_STATUS, 8'h20);
        check({15'h0, control.baudGen0Enable, control.baudGen0Rate}, 32'h0001_1234);
        check({31'h0, irq}, 32'h1);
        xfer(1'b1, 32'h0000_1000 | adr(IDX_STACK_POINTER), 8'hAA, rdat);
        rd_chk(IDX_STACK_POINTER, RST_STACK_POINTER);
        xfer(1'b0, 32'h0000_1000 | adr(IDX_STACK_POINTER), 8'h00, rdat);
        check(rdat, 32'h0);
        wr(IDX_PORT_DATA, 8'h96);
        @(posedge clock);
        check({24'h0, portOut}, 32'h96);
        // second power-on reset in mid-run
        power_on();
        rd_chk(IDX_WATCHDOG_CONTROL, 8'hE5);
        rd_chk(IDX_RTC_CONTROL, RST_RTC_CONTROL);
        rd_chk(IDX_RESET_CAUSE_REGISTER, 8'h30);
        check({24'h0, control.oscTrim}, {24'h0, TRIM_VAL});
        check({31'h0, irq}, 32'h0);
        complete_run();
    end
endmodule
bind sfrb_bank sfrb_bank_checker #(.FACTORY_TRIM(FACTORY_TRIM)) i_chk (.clock(clock), .resetn(resetn),
    .warmReset(warmReset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .control(control), .portOut(portOut), .portOe(portOe), .irq(irq));

/* File: sfrb_pkg.sv */
// constants, register indices and carrier types of the special-function register bank
package sfrb_pkg;

    // ****************************************
    // index widths and counts
    // ****************************************
    localparam int IDX_W = 10;
    localparam int TABLE_COUNT = 24;
    localparam int IRQ_W = 6;
    typedef logic [IDX_W-1:0] sfrb_idx_t;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam sfrb_idx_t IDX_STACK_POINTER = 10'h081;
    localparam sfrb_idx_t IDX_TIMER_RUN_CONTROL = 10'h088;
    localparam sfrb_idx_t IDX_TIMER_MODE_SELECT = 10'h089;
    localparam sfrb_idx_t IDX_TIMER0_COUNT_LOW = 10'h08A;
    localparam sfrb_idx_t IDX_TIMER1_COUNT_LOW = 10'h08B;
    localparam sfrb_idx_t IDX_TIMER0_COUNT_HIGH = 10'h08C;
    localparam sfrb_idx_t IDX_TIMER1_COUNT_HIGH = 10'h08D;
    localparam sfrb_idx_t IDX_TIMER_AUX_MODE = 10'h08F;
    localparam sfrb_idx_t IDX_RC_OSCILLATOR_TUNING = 10'h096;
    localparam sfrb_idx_t IDX_UART0_CONTROL = 10'h098;
    localparam sfrb_idx_t IDX_UART0_BUFFER = 10'h099;
    localparam sfrb_idx_t IDX_WATCHDOG_CONTROL = 10'h0A7;
    localparam sfrb_idx_t IDX_UART0_MATCH_ADDRESS = 10'h0A9;
    localparam sfrb_idx_t IDX_UART1_CONTROL = 10'h0B6;
    localparam sfrb_idx_t IDX_UART0_ADDRESS_MASK = 10'h0B9;
    localparam sfrb_idx_t IDX_UART0_EXTENDED_STATUS = 10'h0BA;
    localparam sfrb_idx_t IDX_WATCHDOG_RELOAD = 10'h0C1;
    localparam sfrb_idx_t IDX_WATCHDOG_SERVICE_FIRST = 10'h0C2;
    localparam sfrb_idx_t IDX_WATCHDOG_SERVICE_SECOND = 10'h0C3;
    localparam sfrb_idx_t IDX_RTC_CONTROL = 10'h0D1;
    localparam sfrb_idx_t IDX_RTC_COUNT_HIGH = 10'h0D2;
    localparam sfrb_idx_t IDX_RTC_COUNT_LOW = 10'h0D3;
    localparam sfrb_idx_t IDX_UART1_EXTENDED_STATUS = 10'h0D4;
    localparam sfrb_idx_t IDX_RESET_CAUSE_REGISTER = 10'h0DF;
    localparam sfrb_idx_t IDX_SPI_STATUS = 10'h0E1;
    localparam sfrb_idx_t IDX_SPI_CONTROL = 10'h0E2;
    localparam sfrb_idx_t IDX_SPI_SHIFT_DATA = 10'h0E3;
    localparam sfrb_idx_t IDX_IRQ_STATUS = 10'h100;
    localparam sfrb_idx_t IDX_IRQ_ENABLE = 10'h101;
    localparam sfrb_idx_t IDX_IRQ_CLEAR = 10'h102;
    localparam sfrb_idx_t IDX_BAUD_GEN0_CONTROL = 10'h103;
    localparam sfrb_idx_t IDX_BAUD_GEN0_RATE_LOW = 10'h104;
    localparam sfrb_idx_t IDX_BAUD_GEN0_RATE_HIGH = 10'h105;
    localparam sfrb_idx_t IDX_PORT_DRIVE = 10'h106;
    localparam sfrb_idx_t IDX_PORT_DATA = 10'h107;

    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_STACK_POINTER = 8'h07;
    localparam logic [7:0] RST_RTC_CONTROL = 8'h60;
    localparam logic [7:0] RST_WATCHDOG_RELOAD = 8'hFF;
    localparam logic [7:0] RST_SPI_CONTROL = 8'h04;
    localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'hE5;
    localparam logic [7:0] RST_RESET_CAUSE_POR = 8'h30;
    localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 1;
    localparam int BAUD_GEN0_ENABLE_BIT = 0;
    localparam int IRQ_BAUD_REFUSED_BIT = 5;

    // ****************************************
    // plain storage table
    // ****************************************
    localparam sfrb_idx_t TABLE_INDEX [TABLE_COUNT] = '{
        IDX_STACK_POINTER, IDX_TIMER_RUN_CONTROL, IDX_TIMER_MODE_SELECT, IDX_TIMER0_COUNT_LOW,
        IDX_TIMER1_COUNT_LOW, IDX_TIMER0_COUNT_HIGH, IDX_TIMER1_COUNT_HIGH, IDX_TIMER_AUX_MODE,
        IDX_UART0_CONTROL, IDX_UART0_BUFFER, IDX_UART0_MATCH_ADDRESS, IDX_UART1_CONTROL,
        IDX_UART0_ADDRESS_MASK, IDX_UART0_EXTENDED_STATUS, IDX_WATCHDOG_RELOAD, IDX_WATCHDOG_SERVICE_FIRST,
        IDX_WATCHDOG_SERVICE_SECOND, IDX_RTC_CONTROL, IDX_RTC_COUNT_HIGH, IDX_RTC_COUNT_LOW,
        IDX_UART1_EXTENDED_STATUS, IDX_SPI_STATUS, IDX_SPI_CONTROL, IDX_SPI_SHIFT_DATA};
    localparam logic [7:0] TABLE_RESET [TABLE_COUNT] = '{
        RST_STACK_POINTER, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_WATCHDOG_RELOAD, RST_ZERO,
        RST_ZERO, RST_RTC_CONTROL, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_SPI_CONTROL, RST_ZERO};
    localparam logic TABLE_POR_ONLY [TABLE_COUNT] = '{
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic brownout;
        logic breakDetect;
        logic watchdog;
        logic software;
        logic external;
    } sfrb_reset_t;

    typedef struct packed {
        logic [7:0] watchdogControl;
        logic [7:0] oscTrim;
        logic baudGen0Enable;
        logic [15:0] baudGen0Rate;
    } sfrb_ctrl_t;

endpackage
